// ### cor_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "cor_defs.svh"
module cor_regs #(
	parameter logic [3:0] REVISION_CODE = 4'h3, // arbitrary value
	parameter logic [3:0] MAKER_CODE    = 4'h9  // arbitrary value
) (
	input  wire logic                       i_clock,
	input  wire logic                       i_rst_n,
	input  wire logic                       i_link_clk,
	input  wire logic                       i_link_start,
	input  wire logic                       i_link_byte_stb,
	input  wire logic [7:0]                 i_link_byte,
	input  wire logic                       i_current_multiplier_select,
	input  wire logic [`COR_IDX_W-1:0]      i_rd_index,
	output logic      [7:0]                 o_rd_data,
	input  wire logic [`COR_NUM_GATED-1:0]  i_raw_clk,
	output logic      [`COR_NUM_GATED-1:0]  o_gated_clk,
	output logic      [2:0]                 o_cpu_free_run,
	output logic      [2:0]                 o_cpu_en,
	output logic      [6:0]                 o_pci_en,
	output logic                            o_video_48m_clock_en,
	output logic                            o_usb_en,
	output logic      [2:0]                 o_pcif_stoppable,
	output logic      [2:0]                 o_pcif_en,
	output logic                            o_mid_freq_clock0_en,
	output logic                            o_video_hub_clock_en,
	output logic                            o_mid_freq_clock5_en,
	output logic      [2:0]                 o_buffered_mid_freq_output_en,
	output logic      [1:0]                 o_buffer_input_pin_delay,
	output logic      [1:0]                 o_video_48m_clock_edge,
	output logic      [1:0]                 o_usb_edge
);
	function automatic logic [7:0] wmask(input logic [2:0] idx);
		case (idx)
			`COR_IDX_CPU:   wmask = `COR_WM_CPU;
			`COR_IDX_PCI:   wmask = `COR_WM_PCI;
			`COR_IDX_USBPF: wmask = `COR_WM_USBPF;
			`COR_IDX_MID:   wmask = `COR_WM_MID;
			`COR_IDX_DLY:   wmask = `COR_WM_DLY;
			default:        wmask = 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] rstval(input logic [2:0] idx);
		case (idx)
			`COR_IDX_CPU:   rstval = `COR_RST_CPU;
			`COR_IDX_PCI:   rstval = `COR_RST_PCI;
			`COR_IDX_USBPF: rstval = `COR_RST_USBPF;
			`COR_IDX_MID:   rstval = `COR_RST_MID;
			`COR_IDX_DLY:   rstval = `COR_RST_DLY;
			default:        rstval = 8'h00;
		endcase
	endfunction

	// ---- link domain: byte position and a held word with a toggle
	logic [5:0] lpos_ff;
	logic [5:0] nxt_lpos;
	logic [2:0] lidx_ff;
	logic [2:0] nxt_lidx;
	logic [7:0] ldata_ff;
	logic [7:0] nxt_ldata;
	logic       ltog_ff;
	logic       nxt_ltog;

	always_comb begin
		nxt_lpos  = lpos_ff;
		nxt_lidx  = lidx_ff;
		nxt_ldata = ldata_ff;
		nxt_ltog  = ltog_ff;
		if (i_link_start) begin
			nxt_lpos = 6'h00;
		end else if (i_link_byte_stb) begin
			// the count can never legally pass 32; saturate anyway
			if (lpos_ff <= 6'h06) begin
				nxt_lidx = lpos_ff[2:0];
			end else begin
				nxt_lidx = `COR_IDX_NONE;
			end
			if (lpos_ff != `COR_LAST_BYTE) nxt_lpos = lpos_ff + 6'h01;
			nxt_ldata = i_link_byte;
			nxt_ltog  = !ltog_ff;
		end
	end

	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lpos_ff  <= 6'h00;
			lidx_ff  <= `COR_IDX_NONE;
			ldata_ff <= 8'h00;
			ltog_ff  <= 1'b0;
		end else begin
			lpos_ff  <= nxt_lpos;
			lidx_ff  <= nxt_lidx;
			ldata_ff <= nxt_ldata;
			ltog_ff  <= nxt_ltog;
		end
	end

	// ---- crossing: the held word is stable for a whole serial byte,
	// far longer than the three core cycles the toggle needs
	logic       tog_sync;
	logic       mult_sync;
	logic       tog_d_ff;
	logic       nxt_tog_d;
	logic       rx_new;
	logic [2:0] rx_idx;
	logic [7:0] rx_data;

	cor_sync2 #(.WIDTH(2)) u_sync (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_async ({ltog_ff, i_current_multiplier_select}),
		.o_sync  ({tog_sync, mult_sync})
	);

	always_comb begin
		nxt_tog_d = tog_sync;
		rx_new    = tog_sync ^ tog_d_ff;
		rx_idx    = lidx_ff;
		rx_data   = ldata_ff;
	end

	// ---- core domain: configuration bytes
	logic [7:0] cfg_ff [1:5];
	logic [7:0] nxt_cfg [1:5];
	logic [7:0] rd_ff;
	logic [7:0] nxt_rd;

	always_comb begin
		for (int i = 1; i <= 5; i++) begin
			nxt_cfg[i] = cfg_ff[i];
			if (rx_new && rx_idx == 3'(i)) begin
				nxt_cfg[i] = rx_data & wmask(3'(i));
			end
		end
		case (i_rd_index)
			`COR_IDX_CPU: begin
				nxt_rd = cfg_ff[1] & `COR_WM_CPU;
				nxt_rd[`COR_MULT_BIT] = mult_sync;
			end
			`COR_IDX_PCI:   nxt_rd = cfg_ff[2];
			`COR_IDX_USBPF: nxt_rd = cfg_ff[3];
			`COR_IDX_MID:   nxt_rd = cfg_ff[4];
			`COR_IDX_DLY:   nxt_rd = cfg_ff[5];
			`COR_IDX_ID:    nxt_rd = {REVISION_CODE, MAKER_CODE};
			default:        nxt_rd = 8'h00;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 1; i <= 5; i++) begin
				cfg_ff[i] <= rstval(3'(i));
			end
			tog_d_ff <= 1'b0;
			rd_ff    <= 8'h00;
		end else begin
			for (int i = 1; i <= 5; i++) begin
				cfg_ff[i] <= nxt_cfg[i];
			end
			tog_d_ff <= nxt_tog_d;
			rd_ff    <= nxt_rd;
		end
	end

	assign o_rd_data        = rd_ff;
	assign o_cpu_free_run   = cfg_ff[1][5:3];
	assign o_cpu_en         = cfg_ff[1][2:0];
	assign o_pci_en         = cfg_ff[2][6:0];
	assign o_video_48m_clock_en = cfg_ff[3][7];
	assign o_usb_en         = cfg_ff[3][6];
	assign o_pcif_stoppable = cfg_ff[3][5:3];
	assign o_pcif_en        = cfg_ff[3][2:0];
	assign o_mid_freq_clock0_en = cfg_ff[4][5];
	assign o_video_hub_clock_en = cfg_ff[4][4];
	// the pin may be an input; clearing this is the host's mistake
	assign o_mid_freq_clock5_en = cfg_ff[4][3];
	assign o_buffered_mid_freq_output_en = cfg_ff[4][2:0];
	assign o_buffer_input_pin_delay = cfg_ff[5][5:4];
	assign o_video_48m_clock_edge   = cfg_ff[5][3:2];
	assign o_usb_edge               = cfg_ff[5][1:0];

	// ---- single-ended outputs: pci, free pci, video, usb, mid, buffered
	logic [`COR_NUM_GATED-1:0] gate_en;
	assign gate_en = {cfg_ff[2][6:0], cfg_ff[3][2:0], cfg_ff[3][7:6],
		cfg_ff[4][5:0]};

	for (genvar g = 0; g < `COR_NUM_GATED; g++) begin : g_gate
		cor_out_gate u_gate (
			.i_clock  (i_clock),
			.i_rst_n  (i_rst_n),
			.i_phase  (i_raw_clk[g]),
			.i_enable (gate_en[g]),
			.o_clk    (o_gated_clk[g])
		);
	end

	// ---- checks
	logic first_ff;
	logic nxt_first;
	assign nxt_first = 1'b0;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			first_ff <= 1'b1;
		end else begin
			first_ff <= nxt_first;
		end
	end

	sequence s_byte(logic [2:0] n);
		rx_new && rx_idx == n;
	endsequence
	sequence s_read(logic [2:0] n);
		i_rd_index == n ##1 1'b1;
	endsequence
	// frame start, byte 0, then byte 1 after two idle link cycles
	sequence s_two_bytes;
		i_link_start ##1 i_link_byte_stb ##3 i_link_byte_stb;
	endsequence

	cpu_free_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s_byte(`COR_IDX_CPU)
		|=> o_cpu_free_run == $past(rx_data[5:3]))
		else $error("cpu free-run bits not written");
	cpu_en_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s_byte(`COR_IDX_CPU)
		|=> o_cpu_en == $past(rx_data[2:0]))
		else $error("cpu enables not written");
	pci_en_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s_byte(`COR_IDX_PCI)
		|=> o_pci_en == $past(rx_data[6:0]) && cfg_ff[2][7] == 1'b0)
		else $error("pci enables wrong");
	usb_video_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s_byte(`COR_IDX_USBPF)
		|=> {o_video_48m_clock_en, o_usb_en} == $past(rx_data[7:6]))
		else $error("48m enables wrong");
	pcif_stop_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s_byte(`COR_IDX_USBPF)
		|=> o_pcif_stoppable == $past(rx_data[5:3]))
		else $error("free pci stop bits wrong");
	pcif_en_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s_byte(`COR_IDX_USBPF)
		|=> o_pcif_en == $past(rx_data[2:0]))
		else $error("free pci enables wrong");
	mid_en_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s_byte(`COR_IDX_MID)
		|=> cfg_ff[4] == ($past(rx_data) & 8'h3F))
		else $error("mid enables wrong");
	buf_en_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s_byte(`COR_IDX_MID)
		|=> o_buffered_mid_freq_output_en == $past(rx_data[2:0]))
		else $error("buffered enables wrong");
	buf_dly_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s_byte(`COR_IDX_DLY)
		|=> o_buffer_input_pin_delay == $past(rx_data[5:4]))
		else $error("delay field wrong");
	edge_rate_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s_byte(`COR_IDX_DLY)
		|=> {o_video_48m_clock_edge, o_usb_edge} == $past(rx_data[3:0]))
		else $error("edge rate fields wrong");
	id_read_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s_read(`COR_IDX_ID)
		|-> o_rd_data == {REVISION_CODE, MAKER_CODE})
		else $error("identity byte wrong");
	mult_read_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s_read(`COR_IDX_CPU)
		|-> o_rd_data[7:6] == {$past(mult_sync), 1'b0})
		else $error("multiplier bit wrong");
	reset_dflt_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) first_ff
		|-> o_cpu_en == 3'h7 && o_pci_en == 7'h7F
		&& o_cpu_free_run == 3'h0
		&& o_pcif_en == 3'h7 && o_pcif_stoppable == 3'h0
		&& o_video_48m_clock_en && o_usb_en && o_mid_freq_clock5_en
		&& o_buffered_mid_freq_output_en == 3'h7
		&& o_buffer_input_pin_delay == 2'h0 && o_usb_edge == 2'h0)
		else $error("defaults wrong after reset");
	ro_write_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s_byte(`COR_IDX_ID)
		|=> $stable(cfg_ff[1]) && $stable(cfg_ff[5]))
		else $error("fixed byte write changed state");
	unused_read_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s_read(3'h0)
		|-> o_rd_data == 8'h00)
		else $error("unused byte reads nonzero");
	link_order_a: assert property (@(posedge i_link_clk)
		disable iff (!i_rst_n) s_two_bytes
		|=> lidx_ff == 3'h1 && lpos_ff == 6'h02)
		else $error("byte order wrong");
endmodule
`default_nettype wire

// ### cor_defs.svh
`ifndef COR_DEFS_SVH
`define COR_DEFS_SVH
`define COR_IDX_W      3
`define COR_IDX_CPU    3'h1
`define COR_IDX_PCI    3'h2
`define COR_IDX_USBPF  3'h3
`define COR_IDX_MID    3'h4
`define COR_IDX_DLY    3'h5
`define COR_IDX_ID     3'h6
`define COR_IDX_NONE   3'h7
`define COR_RST_CPU    8'h07
`define COR_RST_PCI    8'h7F
`define COR_RST_USBPF  8'hC7
`define COR_RST_MID    8'h3F
`define COR_RST_DLY    8'h00
`define COR_WM_CPU     8'h3F
`define COR_WM_PCI     8'h7F
`define COR_WM_USBPF   8'hFF
`define COR_WM_MID     8'h3F
`define COR_WM_DLY     8'h3F
`define COR_MULT_BIT   7
`define COR_LAST_BYTE  6'h20
`define COR_NUM_GATED  18
`endif

// ### cor_pkg.sv
`default_nettype none
package cor_pkg;
	typedef enum logic [1:0] {
		COR_G_OFF = 2'b01,
		COR_G_RUN = 2'b10
	} cor_gate_t;
endpackage
`default_nettype wire

// ### cor_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module cor_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	if (WIDTH < 1) begin : g_bad_width
		$error("cor_sync2: WIDTH must be at least 1");
	end

	always_comb begin
		nxt_meta = i_async;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign o_sync = sync_ff;
endmodule
`default_nettype wire

// ### cor_out_gate.sv
`timescale 1ns/1ps
`default_nettype none
module cor_out_gate (
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	input  wire logic i_phase,
	input  wire logic i_enable,
	output logic      o_clk
);
	cor_pkg::cor_gate_t state_ff;
	cor_pkg::cor_gate_t nxt_state;
	logic               out_ff;
	logic               nxt_out;

	// state changes only while the source is low, so no pulse is cut short
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			cor_pkg::COR_G_OFF: begin
				if (i_enable && !i_phase) nxt_state = cor_pkg::COR_G_RUN;
			end
			cor_pkg::COR_G_RUN: begin
				if (!i_enable && !i_phase) nxt_state = cor_pkg::COR_G_OFF;
			end
			default: nxt_state = cor_pkg::COR_G_OFF;
		endcase
		nxt_out = (nxt_state == cor_pkg::COR_G_RUN) ? i_phase : 1'b0;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff <= cor_pkg::COR_G_OFF;
			out_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			out_ff   <= nxt_out;
		end
	end

	assign o_clk = out_ff;

	gate_low_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) $fell(o_clk) |-> !$past(i_phase))
		else $error("gated clock fell early");
	gate_stop_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) (state_ff == cor_pkg::COR_G_OFF) |-> !o_clk)
		else $error("stopped clock not low");
endmodule
`default_nettype wire

// ### cor_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for the bus host; the link clock runs inside frames and on direct link_cycle calls
module cor_host_model (
	output logic       o_link_clk,
	output logic       o_link_start,
	output logic       o_link_byte_stb,
	output logic [7:0] o_link_byte
);
	initial begin
		o_link_clk = 1'b0;
		o_link_start = 1'b0;
		o_link_byte_stb = 1'b0;
		o_link_byte = 8'h00;
	end

	task link_cycle();
		#15 o_link_clk = 1'b1;
		#15 o_link_clk = 1'b0;
	endtask

	// bytes go out in ascending order from byte 0, no index, 1..7 per frame
	task frame(input logic [55:0] data, input int n);
		o_link_start = 1'b1;
		link_cycle();
		o_link_start = 1'b0;
		for (int i = 0; i < n; i++) begin
			o_link_byte_stb = 1'b1;
			o_link_byte = data[8*i +: 8];
			link_cycle();
			o_link_byte_stb = 1'b0;
			// stale data must not look valid after the strobe
			o_link_byte = ~data[8*i +: 8];
			link_cycle();
			link_cycle();
		end
	endtask
endmodule
`default_nettype wire

// ### clock_output_config_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module clock_output_config_regs_tb_top;
	localparam logic [3:0] REV   = 4'hA; // arbitrary value
	localparam logic [3:0] MAKER = 4'h5; // arbitrary value
	logic        i_clock;
	logic        i_rst_n;
	logic        mult;
	logic [2:0]  i_rd_index;
	logic [17:0] i_raw_clk;
	logic        lclk, lstart, lstb;
	logic [7:0]  lbyte;
	logic [7:0]  o_rd_data;
	logic [17:0] o_gated_clk;
	logic [2:0]  cfr, cen, pst, pen, ben;
	logic [6:0]  pci;
	logic        ven, uen, m0, vh, m5;
	logic [1:0]  dly, vedge, uedge;
	logic [32:0] cfg;
	int          n_fail;
	int          samples_checked;

	assign cfg = {cfr, cen, pci, ven, uen, pst, pen, m0, vh, m5, ben, dly,
		vedge, uedge};

	cor_host_model HOST (
		.o_link_clk     (lclk),
		.o_link_start   (lstart),
		.o_link_byte_stb(lstb),
		.o_link_byte    (lbyte)
	);

	cor_regs #(.REVISION_CODE(REV), .MAKER_CODE(MAKER)) DUT (
		.i_clock                      (i_clock),
		.i_rst_n                      (i_rst_n),
		.i_link_clk                   (lclk),
		.i_link_start                 (lstart),
		.i_link_byte_stb              (lstb),
		.i_link_byte                  (lbyte),
		.i_current_multiplier_select  (mult),
		.i_rd_index                   (i_rd_index),
		.o_rd_data                    (o_rd_data),
		.i_raw_clk                    (i_raw_clk),
		.o_gated_clk                  (o_gated_clk),
		.o_cpu_free_run               (cfr),
		.o_cpu_en                     (cen),
		.o_pci_en                     (pci),
		.o_video_48m_clock_en         (ven),
		.o_usb_en                     (uen),
		.o_pcif_stoppable             (pst),
		.o_pcif_en                    (pen),
		.o_mid_freq_clock0_en         (m0),
		.o_video_hub_clock_en         (vh),
		.o_mid_freq_clock5_en         (m5),
		.o_buffered_mid_freq_output_en(ben),
		.o_buffer_input_pin_delay     (dly),
		.o_video_48m_clock_edge       (vedge),
		.o_usb_edge                   (uedge)
	);

	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end

	task automatic results();
		$display("checks=%0d failures=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [2:0] idx, input logic [7:0] exp);
		@(negedge i_clock);
		i_rd_index = idx;
		@(negedge i_clock);
		chk({25'h0, o_rd_data}, {25'h0, exp});
	endtask

	task automatic check_all(input logic [7:0] b1, b2, b3, b4, b5);
		rd(3'h1, {mult, 1'b0, b1[5:0]});
		rd(3'h2, {1'b0, b2[6:0]});
		rd(3'h3, b3);
		rd(3'h4, {2'b00, b4[5:0]});
		rd(3'h5, {2'b00, b5[5:0]});
		rd(3'h6, {REV, MAKER});
		rd(3'h0, 8'h00);
		rd(3'h7, 8'h00);
		chk(cfg, {b1[5:0], b2[6:0], b3, b4[5:0], b5[5:0]});
	endtask

	// outputs trail the raw pattern by half a core cycle
	task automatic gates(input logic [7:0] b2, b3, b4);
		logic [17:0] m;
		m = {b2[6:0], b3[2:0], b3[7:6], b4[5:0]};
		repeat (6) begin
			@(negedge i_clock);
			chk({15'h0, o_gated_clk}, {15'h0, i_raw_clk & m});
			i_raw_clk = ~i_raw_clk;
		end
	endtask

	initial begin
		#200000;
		n_fail++;
		results();
	end

	initial begin
		n_fail = 0;
		samples_checked = 0;
		i_rst_n = 1'b0;
		mult = 1'b1;
		i_rd_index = 3'h0;
		i_raw_clk = 18'h00000;
		repeat (6) @(negedge i_clock);
		i_rst_n = 1'b1;
		repeat (4) @(negedge i_clock);
		check_all(8'h07, 8'h7F, 8'hC7, 8'h3F, 8'h00);
		gates(8'h7F, 8'hC7, 8'h3F);
		// read-only bits and byte 6 are written with ones, byte 0 with 5A
		HOST.frame(56'hFF_FF_F8_00_FF_FF_5A, 7);
		repeat (8) @(negedge i_clock);
		check_all(8'h3F, 8'h7F, 8'h00, 8'h38, 8'h3F);
		gates(8'h7F, 8'h00, 8'h38);
		mult = 1'b0;
		HOST.frame({40'h0, 8'h00, 8'h00}, 2);
		repeat (8) @(negedge i_clock);
		check_all(8'h00, 8'h7F, 8'h00, 8'h38, 8'h3F);
		HOST.frame(56'h00_00_3F_C7_55_2A_00, 6);
		repeat (8) @(negedge i_clock);
		check_all(8'h2A, 8'h55, 8'hC7, 8'h3F, 8'h00);
		gates(8'h55, 8'hC7, 8'h3F);
		i_rst_n = 1'b0;
		HOST.link_cycle();
		HOST.link_cycle();
		@(negedge i_clock);
		i_rst_n = 1'b1;
		repeat (4) @(negedge i_clock);
		check_all(8'h07, 8'h7F, 8'hC7, 8'h3F, 8'h00);
		results();
	end
endmodule
`default_nettype wire
